// file: pkg/tmo_defs.svh
// constants of the timer overflow and flag control block
`ifndef TMO_DEFS_SVH
`define TMO_DEFS_SVH
// ****************************************************************
// register offsets
// ****************************************************************
`define TMO_OFF_CTRL    8'hc8
`define TMO_OFF_RLD_LO  8'hca
`define TMO_OFF_RLD_HI  8'hcb
`define TMO_OFF_CNT_LO  8'hcc
`define TMO_OFF_CNT_HI  8'hcd
`define TMO_OFF_CLKSEL  8'hce
`define TMO_OFF_IRQ_ST  8'hd0
`define TMO_OFF_IRQ_MSK 8'hd1
// ****************************************************************
// control register fields
// ****************************************************************
`define TMO_CTRL_HI_FLAG 7
`define TMO_CTRL_LO_FLAG 6
`define TMO_CTRL_LO_IEN  5
`define TMO_CTRL_CAP_EN  4
`define TMO_CTRL_SPLIT   3
`define TMO_CTRL_RUN     2
`define TMO_CTRL_XCLK    0
`define TMO_CTRL_WMASK   8'hfd
`define TMO_CTRL_RST     8'h00
// ****************************************************************
// clock select, interrupt status and mask fields
// ****************************************************************
`define TMO_CLK_LO_SYS   0
`define TMO_CLK_HI_SYS   1
`define TMO_IRQ_HI       0
`define TMO_IRQ_LO       1
`define TMO_IRQ_CAP      2
// ****************************************************************
// counts and terminal values
// ****************************************************************
`define TMO_PRESCALE_LAST 4'hb
`define TMO_EXT_DIV_LAST  3'h7
`define TMO_BYTE_MAX      8'hff
`define TMO_WORD_MAX      16'hffff
`endif

// file: pkg/tmo_pkg.sv
// types of the timer overflow and flag control block
package tmo_pkg;
    typedef logic [7:0] tmo_byte_t;

    typedef struct packed {
        tmo_byte_t   ctrl;
        logic [1:0]  clksel;
        logic [15:0] count;
        logic [15:0] reload;
        logic [3:0]  pre;
        logic [2:0]  ist;
        logic [2:0]  imsk;
        tmo_byte_t   rdata;
        logic        irq;
    } tmo_state_s;

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       s3;
        logic [2:0] div;
        logic       tick;
    } tmo_ext_s;
endpackage

// file: pkg/tmo_if.sv
// event carrier from the external clock divider to the timer
`timescale 1ns/1ps
`default_nettype none
interface tmo_ext_if;
    logic ext_tick;
    modport src (output ext_tick);
    modport snk (input ext_tick);
endinterface
`default_nettype wire

// file: hdl/tmo_ext_div.sv
// external oscillator synchroniser and divide-by-eight event source
`timescale 1ns/1ps
`default_nettype none
`include "tmo_defs.svh"
module tmo_ext_div (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   arst_n,
    // external oscillator pin
    input  wire logic   ext_osc_clk,
    // event toward the timer
    tmo_ext_if.src      ev
);
    tmo_pkg::tmo_ext_s q;
    tmo_pkg::tmo_ext_s d;
    logic              rise;

    // ****************************************************************
    // sync, edge detect, divide
    // ****************************************************************
    assign rise = q.s2 & ~q.s3;

    always_comb begin
        d      = q;
        d.s1   = ext_osc_clk;
        d.s2   = q.s1;
        d.s3   = q.s2;
        d.tick = 1'b0;
        if (rise) begin
            d.div = q.div + 3'h1;
            // one-cycle event pulse when the count wraps to zero
            d.tick = (q.div == `TMO_EXT_DIV_LAST);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ev.ext_tick = q.tick;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_EXT_TICK: assert property (rise && q.div == `TMO_EXT_DIV_LAST |=> q.tick && q.div == 3'h0)
        else $error("divide-by-eight event missing");
    AST_EXT_ONLY: assert property (q.tick |-> $past(rise) && $past(q.div) == `TMO_EXT_DIV_LAST)
        else $error("spurious external event");
endmodule
`default_nettype wire

// file: hdl/tmo_timer.sv
// timer with overflow flags, capture, split mode and register port
`timescale 1ns/1ps
`default_nettype none
`include "tmo_defs.svh"
module tmo_timer (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output var  logic [7:0] rdata,
    // external oscillator pin
    input  wire logic       ext_osc_clk,
    // interrupt request
    output var  logic       irq
);
    tmo_pkg::tmo_state_s q;
    tmo_pkg::tmo_state_s d;
    tmo_ext_if           ext_if ();
    logic                split;
    logic                run;
    logic                pre_tick;
    logic                src_tick;
    logic                tick_lo;
    logic                tick_hi;
    logic                wrap_lo;
    logic                wrap_hi;
    logic                wrap16;
    logic                cap;
    logic                hi_set;
    logic                lo_set;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    tmo_ext_div u_ext (
        .clk         (clk),
        .arst_n      (arst_n),
        .ext_osc_clk (ext_osc_clk),
        .ev          (ext_if.src)
    );

    // ****************************************************************
    // tick and event decode
    // ****************************************************************
    assign split    = q.ctrl[`TMO_CTRL_SPLIT];
    assign run      = q.ctrl[`TMO_CTRL_RUN];
    assign pre_tick = (q.pre == `TMO_PRESCALE_LAST);
    // capture mode measures the external clock, so it never counts it
    assign src_tick = (q.ctrl[`TMO_CTRL_XCLK] & ~q.ctrl[`TMO_CTRL_CAP_EN]) ? ext_if.ext_tick : pre_tick;
    // low half free-runs in split mode
    assign tick_lo  = (split | run) & (q.clksel[`TMO_CLK_LO_SYS] | src_tick);
    assign tick_hi  = split & run & (q.clksel[`TMO_CLK_HI_SYS] | src_tick);
    assign wrap_lo  = tick_lo & (q.count[7:0] == `TMO_BYTE_MAX);
    assign wrap_hi  = tick_hi & (q.count[15:8] == `TMO_BYTE_MAX);
    assign wrap16   = ~split & tick_lo & (q.count == `TMO_WORD_MAX);
    assign cap      = q.ctrl[`TMO_CTRL_CAP_EN] & ext_if.ext_tick;
    assign hi_set   = wrap_hi | wrap16 | cap;
    assign lo_set   = wrap_lo;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        d       = q;
        d.rdata = 8'h00;
        d.pre   = pre_tick ? 4'h0 : q.pre + 4'h1;

        // counting datapath
        if (split) begin
            if (tick_lo) begin
                d.count[7:0] = wrap_lo ? q.reload[7:0] : q.count[7:0] + 8'h01;
            end
            if (tick_hi) begin
                d.count[15:8] = wrap_hi ? q.reload[15:8] : q.count[15:8] + 8'h01;
            end
        end else if (tick_lo) begin
            d.count = wrap16 ? q.reload : q.count + 16'h0001;
        end

        // software writes; a count write overrides the tick
        if (wr) begin
            if (hit(addr, `TMO_OFF_CTRL)) begin
                d.ctrl = wdata & `TMO_CTRL_WMASK;
            end
            if (hit(addr, `TMO_OFF_RLD_LO)) begin
                d.reload[7:0] = wdata;
            end
            if (hit(addr, `TMO_OFF_RLD_HI)) begin
                d.reload[15:8] = wdata;
            end
            if (hit(addr, `TMO_OFF_CNT_LO)) begin
                d.count[7:0] = wdata;
            end
            if (hit(addr, `TMO_OFF_CNT_HI)) begin
                d.count[15:8] = wdata;
            end
            if (hit(addr, `TMO_OFF_CLKSEL)) begin
                d.clksel = wdata[1:0];
            end
            if (hit(addr, `TMO_OFF_IRQ_MSK)) begin
                d.imsk = wdata[2:0];
            end
            if (hit(addr, `TMO_OFF_IRQ_ST)) begin
                d.ist = q.ist & ~wdata[2:0];
            end
        end

        // capture wins over a reload write in the same cycle
        if (cap) begin
            d.reload = q.count;
        end

        // hardware sets win over any clear; nothing else clears the flags
        if (hi_set) begin
            d.ctrl[`TMO_CTRL_HI_FLAG] = 1'b1;
        end
        if (lo_set) begin
            d.ctrl[`TMO_CTRL_LO_FLAG] = 1'b1;
        end

        // sticky interrupt causes, set over write-one-to-clear
        for (int i = 0; i < 3; i++) begin
            if ((i == `TMO_IRQ_HI && hi_set) ||
                (i == `TMO_IRQ_LO && lo_set && q.ctrl[`TMO_CTRL_LO_IEN]) ||
                (i == `TMO_IRQ_CAP && cap)) begin
                d.ist[i] = 1'b1;
            end
        end
        d.irq = |(d.ist & d.imsk);

        if (rd) begin
            case (addr)
                `TMO_OFF_CTRL:    d.rdata = q.ctrl;
                `TMO_OFF_RLD_LO:  d.rdata = q.reload[7:0];
                `TMO_OFF_RLD_HI:  d.rdata = q.reload[15:8];
                `TMO_OFF_CNT_LO:  d.rdata = q.count[7:0];
                `TMO_OFF_CNT_HI:  d.rdata = q.count[15:8];
                `TMO_OFF_CLKSEL:  d.rdata = {6'h00, q.clksel};
                `TMO_OFF_IRQ_ST:  d.rdata = {5'h00, q.ist};
                `TMO_OFF_IRQ_MSK: d.rdata = {5'h00, q.imsk};
                default:          d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q      <= '0;
            q.ctrl <= `TMO_CTRL_RST;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign irq   = q.irq;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic ctrl_wr;
    assign ctrl_wr = wr & hit(addr, `TMO_OFF_CTRL);

    AST_HI_SPLIT_WRAP: assert property (
        split && tick_hi && q.count[15:8] == `TMO_BYTE_MAX && !wr
        |=> q.ctrl[`TMO_CTRL_HI_FLAG] && q.count[15:8] == $past(q.reload[15:8]))
        else $error("high byte wrap did not set flag or reload");
    AST_WORD_WRAP: assert property (
        !split && tick_lo && q.count == `TMO_WORD_MAX && !wr
        |=> q.ctrl[`TMO_CTRL_HI_FLAG] && q.ctrl[`TMO_CTRL_LO_FLAG] && q.count == $past(q.reload))
        else $error("word wrap did not set flags or reload");
    AST_HI_IRQ: assert property (
        hi_set && q.imsk[`TMO_IRQ_HI] && !(wr && addr == `TMO_OFF_IRQ_MSK) |=> irq)
        else $error("high flag did not raise interrupt");
    AST_HI_STICKY: assert property (
        q.ctrl[`TMO_CTRL_HI_FLAG] && !ctrl_wr |=> q.ctrl[`TMO_CTRL_HI_FLAG])
        else $error("high flag cleared without write");
    AST_LO_WRAP: assert property (
        tick_lo && q.count[7:0] == `TMO_BYTE_MAX |=> q.ctrl[`TMO_CTRL_LO_FLAG])
        else $error("low byte wrap did not set flag");
    AST_LO_STICKY: assert property (
        q.ctrl[`TMO_CTRL_LO_FLAG] && !ctrl_wr |=> q.ctrl[`TMO_CTRL_LO_FLAG])
        else $error("low flag cleared without write");
    AST_SET_WINS: assert property (
        ctrl_wr && !wdata[`TMO_CTRL_HI_FLAG] && hi_set |=> q.ctrl[`TMO_CTRL_HI_FLAG])
        else $error("software clear beat hardware set");
    AST_SPLIT_LO: assert property (
        split && tick_lo && q.count[7:0] == `TMO_BYTE_MAX && !wr
        |=> q.count[7:0] == $past(q.reload[7:0])
            && q.count[15:8] == ($past(wrap_hi) ? $past(q.reload[15:8])
                                                : $past(q.count[15:8]) + {7'h00, $past(tick_hi)}))
        else $error("split low half did not reload alone");
    AST_LO_IRQ: assert property (
        lo_set && q.ctrl[`TMO_CTRL_LO_IEN] && q.imsk[`TMO_IRQ_LO] && !(wr && addr == `TMO_OFF_IRQ_MSK) |=> irq)
        else $error("low byte overflow did not raise interrupt");
    AST_CAPTURE: assert property (
        cap |=> q.reload == $past(q.count) && q.ctrl[`TMO_CTRL_HI_FLAG])
        else $error("capture did not copy count");

    COV_WORD_WRAP: cover property (wrap16 ##1 irq);
    COV_SPLIT_BOTH: cover property (split && wrap_lo && wrap_hi);
    COV_CAPTURE: cover property (cap ##[1:50] cap);
    COV_SET_CLEAR: cover property (ctrl_wr && hi_set);
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench of the timer overflow and flag control block
`timescale 1ns/1ps
`default_nettype none
`include "tmo_defs.svh"
module tb_top;
    // ****************************************************************
    // signals and instance
    // ****************************************************************
    logic       clk;
    logic       arst_n;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       ext_osc_clk;
    logic       irq;
    int         failures;
    int         comparisons;
    int         cycles;
    int         seed;
    logic [7:0] rv;
    logic [7:0] got;

    tmo_timer u_tmo_timer (
        .clk         (clk),
        .arst_n      (arst_n),
        .addr        (addr),
        .wdata       (wdata),
        .wr          (wr),
        .rd          (rd),
        .rdata       (rdata),
        .ext_osc_clk (ext_osc_clk),
        .irq         (irq)
    );

    always #10 clk = ~clk;

    // ****************************************************************
    // bus tasks and comparison
    // ****************************************************************
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (failures == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        clk = 1'b0; arst_n = 1'b0; addr = 8'h00; wdata = 8'h00;
        wr = 1'b0; rd = 1'b0; ext_osc_clk = 1'b0;
        failures = 0; comparisons = 0; cycles = 0; seed = 21;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        // reset values, unused bit, unmapped place
        rd_reg(`TMO_OFF_CTRL, got); check(got, 8'h00);
        @(posedge clk); #1; check(rdata, 8'h00);
        check({7'h00, irq}, 8'h00);
        rd_reg(8'hc9, got); check(got, 8'h00);
        wr_reg(`TMO_OFF_CTRL, 8'hff);
        rd_reg(`TMO_OFF_CTRL, got); check(got, 8'hfd);
        wr_reg(`TMO_OFF_CTRL, 8'h00);
        wr_reg(`TMO_OFF_IRQ_MSK, 8'h07);
        // sixteen-bit wrap with random reload high byte
        rv = 8'($random(seed));
        wr_reg(`TMO_OFF_CLKSEL, 8'h03);
        wr_reg(`TMO_OFF_RLD_HI, rv);
        wr_reg(`TMO_OFF_RLD_LO, 8'h00);
        wr_reg(`TMO_OFF_CNT_LO, 8'hfe);
        wr_reg(`TMO_OFF_CNT_HI, 8'hff);
        wr_reg(`TMO_OFF_CTRL, 8'h04);
        repeat (4) @(posedge clk);
        rd_reg(`TMO_OFF_CTRL, got); check(got, 8'hc4);
        rd_reg(`TMO_OFF_CNT_HI, got); check(got, rv);
        rd_reg(`TMO_OFF_IRQ_ST, got); check(got, 8'h01);
        check({7'h00, irq}, 8'h01);
        wr_reg(`TMO_OFF_IRQ_ST, 8'h01);
        @(posedge clk); #1;
        check({7'h00, irq}, 8'h00);
        // flags survive the interrupt clear, go only by software write
        rd_reg(`TMO_OFF_CTRL, got); check(got, 8'hc4);
        wr_reg(`TMO_OFF_CTRL, 8'h04);
        rd_reg(`TMO_OFF_CTRL, got); check(got, 8'h04);
        // split mode: low half runs alone, no carry into a stopped high half
        wr_reg(`TMO_OFF_CTRL, 8'h00);
        wr_reg(`TMO_OFF_IRQ_ST, 8'h07);
        wr_reg(`TMO_OFF_CLKSEL, 8'h01);
        wr_reg(`TMO_OFF_CNT_HI, 8'h3c);
        wr_reg(`TMO_OFF_CNT_LO, 8'hfe);
        wr_reg(`TMO_OFF_CTRL, 8'h28);
        repeat (4) @(posedge clk);
        rd_reg(`TMO_OFF_CTRL, got); check(got, 8'h68);
        rd_reg(`TMO_OFF_CNT_HI, got); check(got, 8'h3c);
        rd_reg(`TMO_OFF_IRQ_ST, got); check(got, 8'h02);
        check({7'h00, irq}, 8'h01);
        wr_reg(`TMO_OFF_IRQ_MSK, 8'h00);
        @(posedge clk); #1;
        check({7'h00, irq}, 8'h00);
        // capture on the eighth synchronised external edge
        wr_reg(`TMO_OFF_CTRL, 8'h00);
        wr_reg(`TMO_OFF_IRQ_ST, 8'h07);
        wr_reg(`TMO_OFF_IRQ_MSK, 8'h07);
        wr_reg(`TMO_OFF_CLKSEL, 8'h03);
        wr_reg(`TMO_OFF_CNT_HI, 8'h55);
        wr_reg(`TMO_OFF_CNT_LO, 8'h00);
        wr_reg(`TMO_OFF_CTRL, 8'h14);
        repeat (14) begin
            repeat (3) @(posedge clk);
            ext_osc_clk <= ~ext_osc_clk;
        end
        repeat (8) @(posedge clk);
        rd_reg(`TMO_OFF_CTRL, got); check(got, 8'h14);
        repeat (3) @(posedge clk);
        ext_osc_clk <= ~ext_osc_clk;
        repeat (8) @(posedge clk);
        rd_reg(`TMO_OFF_CTRL, got); check(got, 8'h94);
        rd_reg(`TMO_OFF_RLD_HI, got); check(got, 8'h55);
        rd_reg(`TMO_OFF_IRQ_ST, got); check(got & 8'h04, 8'h04);
        check({7'h00, irq}, 8'h01);
        // split mode, high half clocked by the external divide-by-eight
        wr_reg(`TMO_OFF_IRQ_ST, 8'h07);
        wr_reg(`TMO_OFF_CLKSEL, 8'h01);
        wr_reg(`TMO_OFF_CNT_LO, 8'h00);
        wr_reg(`TMO_OFF_CNT_HI, 8'hfe);
        wr_reg(`TMO_OFF_CTRL, 8'h0d);
        repeat (32) begin
            repeat (3) @(posedge clk);
            ext_osc_clk <= ~ext_osc_clk;
        end
        repeat (8) @(posedge clk);
        rd_reg(`TMO_OFF_CTRL, got); check(got, 8'h8d);
        rd_reg(`TMO_OFF_CNT_HI, got); check(got, 8'h55);
        rd_reg(`TMO_OFF_IRQ_ST, got); check(got, 8'h01);
        check({7'h00, irq}, 8'h01);
        print_verdict();
    end
endmodule
`default_nettype wire
